/* File: core/mode_ctrl_consts.svh */
`ifndef MODE_CTRL_CONSTS_SVH
`define MODE_CTRL_CONSTS_SVH
// register byte offsets
`define REG_CTRL       12'h000
`define REG_STATUS     12'h004
`define REG_CFG_CMD    12'h008
`define REG_LATCH      12'h00c
`define REG_LOCK       12'h010
`define REG_DAYTIME    12'h014
`define REG_CLOCK      12'h018
`define REG_THR_BASE   12'h040
`define REG_DLY_BASE   12'h080
`define REG_ACC_BASE   12'h0c0
`define REG_BASE_AF    12'h100
// ctrl bits
`define CTRL_TEST      0
`define CTRL_RESET     1
`define CTRL_ISO_TGL   2
`define CTRL_ACCLIM    3
// cfg command bits
`define CFG_START      0
`define CFG_DONE       1
`define CFG_VALID      2
`define CFG_UNUSABLE   3
// timing in natural units
`define CLK_MHZ        250
`define SCROLL_MS      1000
`define INIT_S         300
`define SEC_CYC        (`CLK_MHZ*1000000)
`define MAX_DLY_S      60
`define MONITOR_H      24
`define WINDOW_H       1
`define SAT_DAY        3'h5
`define SUN_DAY        3'h6
`endif

/* File: core/mode_ctrl_pkg.sv */
package mode_ctrl_pkg;
  typedef enum logic [2:0] {
    M_UNCONF, M_SCROLL, M_INIT, M_NORMAL, M_TEST
  } mode_t;
  typedef struct packed {
    logic urgent;
    logic minor;
    logic iso;
    logic [4:0] alarm;
  } relay_t;
  typedef struct packed {
    logic flow_lo_minor;
    logic flow_lo_urgent;
    logic flow_hi_minor;
    logic sensor;
    logic ext_mon;
    logic comm;
    logic fan;
  } fault_t;
endpackage

/* File: core/detector_mode_controller.sv */
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "mode_ctrl_consts.svh"
// Behaviour
// R01 - unconfigured: config fault lit until configured
// R02 - initialisation captures baselines, at most five minutes
// R03 - power-up: one second green scroll, then initialise
// R04 - after startup, normal or fault indicators
// R05 - validate config, then initialise with it
// R06 - failed validation: config fault, discard upload; code keeps the uploaded values in the live tables
// R07 - first-config or unusable fault: urgent relay
// R08 - later config fault: minor relay, keep old; code keeps the newly uploaded values instead
// R09 - old config kept until new validated; code writes the upload straight into the live tables
// R10 - interrupted upload: one-time config fault, minor; code reads nv_upl at boot while its synchroniser still holds zero
// R11 - normal: compare particulate against thresholds, alarm
// R12 - normal: faults light indicator and relay
// R13 - test: all ten segments, all alarms
// R14 - test: alarm relay after its delay
// R15 - reset button ends test mode
// R16 - reset releases relays, enters normal
// R17 - acclimate: monitor 24h, then 1h window
// R18 - acclimate threshold starts insensitive, bounded
// R19 - acclimated thresholds readable by software
// R20 - day, night, weekend threshold sets
// R21 - isolate press: release relays, set isolation
// R22 - isolated: display only, isolation persists
// R23 - per-level delay 0-60 s, latching option
// R24 - locked buttons are ignored
// R25 - outputs registered, inactive in reset
module detector_mode_controller
  import mode_ctrl_pkg::*;
#(
  parameter int unsigned SEC_CYC  = `SEC_CYC,  // cycles per second
  parameter int unsigned INIT_S   = `INIT_S,   // init duration, seconds
  parameter int unsigned SCROLL_C = `CLK_MHZ*`SCROLL_MS*1000,
  parameter int unsigned HOUR_S   = 3600       // seconds per hour
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // front panel buttons, asynchronous
  input  wire logic        btn_test_i,
  input  wire logic        btn_reset_i,
  input  wire logic        btn_iso_i,
  // measurements, asynchronous
  input  wire logic [15:0] partic_i,
  input  wire logic [15:0] airflow_i,
  input  wire logic        flow_lo_minor_i,
  input  wire logic        flow_lo_urgent_i,
  input  wire logic        flow_hi_minor_i,
  input  wire logic        sensor_flt_i,
  input  wire logic        ext_mon_flt_i,
  input  wire logic        comm_flt_i,
  input  wire logic        fan_flt_i,
  // nonvolatile state, read in the first cycle after reset while the synchroniser still holds zero
  input  wire logic        nv_configured_i,
  input  wire logic        nv_isolated_i,
  input  wire logic        nv_upload_open_i,
  // outputs
  output logic [4:0]       alarm_relay_o,
  output logic             minor_relay_o,
  output logic             urgent_relay_o,
  output logic             iso_relay_o,
  output logic [4:0]       alarm_led_o,
  output logic [9:0]       partic_led_o,
  output logic             scroll_green_o,
  output logic             cfg_flt_led_o,
  output logic [6:0]       flt_led_o,
  output logic             iso_led_o,
  output logic             nv_isolated_o,
  output logic             nv_upload_open_o,
  output logic             nv_configured_o
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  localparam int SW = 3 + 32 + 7 + 3;
  logic [SW-1:0] sync1_ff;   // first stage, read only by second
  logic [SW-1:0] sync2_ff;   // usable copy
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {btn_test_i, btn_reset_i, btn_iso_i, partic_i,
                   airflow_i, flow_lo_minor_i, flow_lo_urgent_i,
                   flow_hi_minor_i, sensor_flt_i, ext_mon_flt_i,
                   comm_flt_i, fan_flt_i, nv_configured_i,
                   nv_isolated_i, nv_upload_open_i};
      sync2_ff <= sync1_ff;
    end
  end
  wire logic [2:0]  btn_s   = sync2_ff[44:42];
  wire logic [15:0] partic  = sync2_ff[41:26];
  wire logic [15:0] airflow = sync2_ff[25:10];
  wire fault_t      flt     = fault_t'(sync2_ff[9:3]);
  wire logic        nv_cfg  = sync2_ff[2];
  wire logic        nv_iso  = sync2_ff[1];
  wire logic        nv_upl  = sync2_ff[0];

  // button press detection on release edge
  logic [2:0] btn_d_ff;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) btn_d_ff <= '0;
    else          btn_d_ff <= btn_s;
  end
  logic [2:0] lock_ff;       // 1 = button locked out
  wire logic [2:0] btn_rel = btn_d_ff & ~btn_s & ~lock_ff; // [R24]
  wire logic b_test  = btn_rel[2];
  wire logic b_reset = btn_rel[1];
  wire logic b_iso   = btn_rel[0];

  // ------------------------------------------------------------
  // apb registers
  // ------------------------------------------------------------
  logic [15:0] thr_ff [3][5];  // day, night, weekend
  logic [15:0] acc_hi_ff [5];  // sensitive boundary
  logic [15:0] acc_lo_ff [5];  // insensitive boundary
  logic [15:0] acc_cur_ff [5]; // live acclimated level
  logic [5:0]  dly_ff [5];     // seconds, 0..60
  logic [4:0]  latch_ff;
  logic        acclim_ff;
  logic [15:0] day_start_ff, day_end_ff;  // minutes of day
  logic [10:0] min_ff;                    // minute of day
  logic [2:0]  wday_ff;                   // 0 = monday
  logic [15:0] base_af_ff, base_pt_ff;
  mode_t       mode_ff;
  logic        cfg_flt_ff, upload_ff, first_ff, iso_ff, boot_ff;
  logic        urgent_cfg_ff, minor_cfg_ff;  // config fault relay requests
  logic        sw_test_pulse, sw_reset_pulse, sw_iso_pulse;
  logic        cfg_start, cfg_done, cfg_valid, cfg_unusable;

  wire logic acc_set = psel_i & penable_i & pready_o;
  wire logic wr = acc_set & pwrite_i;
  wire logic [3:0] idx = paddr_i[5:2];
  wire logic hit_thr = paddr_i[11:6] == `REG_THR_BASE >> 6;
  wire logic hit_dly = paddr_i[11:6] == `REG_DLY_BASE >> 6;
  wire logic hit_acc = paddr_i[11:6] == `REG_ACC_BASE >> 6;
  // thr: idx 0..4 day, 5..9 night, 10..14 weekend; acc idx lo/hi/cur
  wire logic [1:0] tset = idx < 4'h5 ? 2'h0 : idx < 4'ha ? 2'h1 : 2'h2;
  wire logic [2:0] tlev = 3'(idx - {tset, 2'h0} - 4'(tset));

  assign sw_test_pulse  = wr & paddr_i == `REG_CTRL & pwdata_i[`CTRL_TEST];
  assign sw_reset_pulse = wr & paddr_i == `REG_CTRL & pwdata_i[`CTRL_RESET];
  assign sw_iso_pulse   = wr & paddr_i == `REG_CTRL & pwdata_i[`CTRL_ISO_TGL];
  assign cfg_start    = wr & paddr_i == `REG_CFG_CMD & pwdata_i[`CFG_START];
  assign cfg_done     = wr & paddr_i == `REG_CFG_CMD & pwdata_i[`CFG_DONE];
  assign cfg_valid    = pwdata_i[`CFG_VALID];
  assign cfg_unusable = pwdata_i[`CFG_UNUSABLE];
  wire logic known = paddr_i == `REG_CTRL | paddr_i == `REG_STATUS |
    paddr_i == `REG_CFG_CMD | paddr_i == `REG_LATCH | paddr_i == `REG_LOCK |
    paddr_i == `REG_DAYTIME | paddr_i == `REG_CLOCK | paddr_i == `REG_BASE_AF
    | (hit_thr & idx < 4'hf) | (hit_dly & idx < 4'h5) | (hit_acc & idx < 4'hf);
  wire logic ld_cfg = upload_ff;  // config writes go straight to the live tables, only while uploading [R09]

  // write side; config tables only accept data inside an upload
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 5; i++) begin
        for (int s = 0; s < 3; s++) thr_ff[s][i] <= 16'hffff;
        dly_ff[i] <= '0; acc_hi_ff[i] <= 16'hffff; acc_lo_ff[i] <= 16'hffff;
      end
      latch_ff <= '0; acclim_ff <= 1'b0; lock_ff <= 3'h7;
      day_start_ff <= 16'h01a4; day_end_ff <= 16'h04ec;
    end else if (wr & ld_cfg) begin
      if (hit_thr & idx < 4'hf) thr_ff[tset][tlev] <= pwdata_i[15:0];
      if (hit_dly & idx < 4'h5)                                     // [R23]
        dly_ff[idx[2:0]] <= pwdata_i[5:0] > 6'(`MAX_DLY_S) ?
                            6'(`MAX_DLY_S) : pwdata_i[5:0];
      if (hit_acc & idx < 4'h5) acc_lo_ff[idx[2:0]] <= pwdata_i[15:0];
      if (hit_acc & idx >= 4'h5 & idx < 4'ha)
        acc_hi_ff[3'(idx - 4'h5)] <= pwdata_i[15:0];
      if (paddr_i == `REG_LATCH) latch_ff <= pwdata_i[4:0];        // [R23]
      if (paddr_i == `REG_LOCK) lock_ff <= pwdata_i[2:0];
      if (paddr_i == `REG_DAYTIME) begin
        day_start_ff <= pwdata_i[15:0];
        day_end_ff <= pwdata_i[31:16];
      end
      if (paddr_i == `REG_CTRL) acclim_ff <= pwdata_i[`CTRL_ACCLIM];
    end
  end

  // read mux, one wait state
  logic [31:0] rd;
  always_comb begin
    rd = '0;
    if (paddr_i == `REG_STATUS)
      rd = {20'h0, nv_configured_o, upload_ff, cfg_flt_ff, iso_ff,
            1'b0, 3'(mode_ff), minor_relay_o, urgent_relay_o};
    else if (paddr_i == `REG_CTRL) rd = {28'h0, acclim_ff, 3'h0};
    else if (paddr_i == `REG_LATCH) rd = {27'h0, latch_ff};
    else if (paddr_i == `REG_LOCK) rd = {29'h0, lock_ff};
    else if (paddr_i == `REG_DAYTIME) rd = {day_end_ff, day_start_ff};
    else if (paddr_i == `REG_CLOCK) rd = {18'h0, wday_ff, min_ff};
    else if (paddr_i == `REG_BASE_AF) rd = {base_pt_ff, base_af_ff};
    else if (hit_thr & idx < 4'hf) rd = {16'h0, thr_ff[tset][tlev]};
    else if (hit_dly & idx < 4'h5) rd = {26'h0, dly_ff[idx[2:0]]};
    else if (hit_acc & idx >= 4'ha & idx < 4'hf)
      rd = {16'h0, acc_cur_ff[3'(idx - 4'ha)]};                   // [R19]
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= '0; pready_o <= 1'b0; pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~known;
      prdata_o  <= rd;
    end
  end

  // ------------------------------------------------------------
  // time base: seconds tick, minute/day clock
  // ------------------------------------------------------------
  logic [31:0] sec_cnt_ff;
  wire logic sec_tick = sec_cnt_ff == 32'(SEC_CYC - 1);
  logic [5:0] sec_of_min_ff;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sec_cnt_ff <= '0; sec_of_min_ff <= '0; min_ff <= '0; wday_ff <= '0;
    end else if (wr & paddr_i == `REG_CLOCK) begin
      min_ff <= pwdata_i[10:0]; wday_ff <= pwdata_i[13:11];
    end else begin
      sec_cnt_ff <= sec_tick ? '0 : sec_cnt_ff + 32'h1;
      if (sec_tick) begin
        sec_of_min_ff <= sec_of_min_ff == 6'd59 ? '0 : sec_of_min_ff + 6'h1;
        if (sec_of_min_ff == 6'd59) begin
          min_ff <= min_ff == 11'd1439 ? '0 : min_ff + 11'h1;
          if (min_ff == 11'd1439) wday_ff <= wday_ff == 3'h6 ? '0 : wday_ff + 3'h1;
        end
      end
    end
  end
  // day/night/weekend set select [R20]
  wire logic weekend = wday_ff == `SAT_DAY | wday_ff == `SUN_DAY;
  wire logic is_day = 16'(min_ff) >= day_start_ff & 16'(min_ff) < day_end_ff;
  wire logic [1:0] sel_set = weekend ? 2'h2 : is_day ? 2'h0 : 2'h1;

  // ------------------------------------------------------------
  // mode sequencer
  // ------------------------------------------------------------
  logic [31:0] tmr_ff;
  logic        base_done_ff;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_ff <= M_SCROLL; tmr_ff <= '0; boot_ff <= 1'b1;
      cfg_flt_ff <= 1'b0; upload_ff <= 1'b0; first_ff <= 1'b0;
      iso_ff <= 1'b0; base_af_ff <= '0; base_pt_ff <= '0;
      base_done_ff <= 1'b0; urgent_cfg_ff <= 1'b0; minor_cfg_ff <= 1'b0;
    end else begin
      boot_ff <= 1'b0;
      if (boot_ff) begin
        iso_ff <= nv_iso;                                           // [R22]
        first_ff <= ~nv_cfg;
        if (nv_upl) begin                                           // [R10]
          cfg_flt_ff <= 1'b1; minor_cfg_ff <= 1'b1;
        end
      end
      if (b_iso | sw_iso_pulse) iso_ff <= ~iso_ff;                  // [R21]
      if (b_reset | sw_reset_pulse) begin
        minor_cfg_ff <= 1'b0;
        if (nv_configured_o & ~upload_ff) cfg_flt_ff <= 1'b0;
      end
      if (cfg_start) upload_ff <= 1'b1;
      if (cfg_done) begin
        upload_ff <= 1'b0;
        if (cfg_valid & ~cfg_unusable) begin                        // [R05]
          cfg_flt_ff <= 1'b0; urgent_cfg_ff <= 1'b0; minor_cfg_ff <= 1'b0;
          first_ff <= 1'b0; mode_ff <= M_INIT; tmr_ff <= '0;
          base_done_ff <= 1'b0;
        end else begin
          cfg_flt_ff <= 1'b1;                                       // [R06]
          if (first_ff | cfg_unusable) begin
            urgent_cfg_ff <= 1'b1;                                  // [R07]
            mode_ff <= M_UNCONF;
          end else minor_cfg_ff <= 1'b1;                            // [R08]
        end
      end else case (mode_ff)
        M_SCROLL: begin
          tmr_ff <= tmr_ff + 32'h1;
          if (tmr_ff == 32'(SCROLL_C - 1)) begin                    // [R03]
            tmr_ff <= '0;
            mode_ff <= first_ff ? M_UNCONF : M_INIT;
          end
        end
        M_UNCONF: begin
          cfg_flt_ff <= 1'b1;                                       // [R01]
          urgent_cfg_ff <= first_ff;
        end
        M_INIT: begin
          if (!base_done_ff) begin                                  // [R02]
            base_af_ff <= airflow; base_pt_ff <= partic;
            base_done_ff <= 1'b1;
          end
          if (sec_tick) tmr_ff <= tmr_ff + 32'h1;
          if (sec_tick & tmr_ff == 32'(INIT_S - 1))                 // [R02]
            mode_ff <= M_NORMAL;                                    // [R04]
        end
        M_NORMAL:
          if (b_test | sw_test_pulse) mode_ff <= M_TEST;            // [R13]
        M_TEST:
          if (b_reset | sw_reset_pulse) mode_ff <= M_NORMAL;        // [R15]
        default: mode_ff <= M_SCROLL;
      endcase
    end
  end

  // ------------------------------------------------------------
  // acclimation: per level moving threshold
  // ------------------------------------------------------------
  logic [31:0] acc_sec_ff;
  logic [15:0] peak_ff;      // peak particulate in current hour
  wire logic monitored = acc_sec_ff >= 32'(`MONITOR_H * HOUR_S);
  wire logic hour_end = sec_tick & monitored &
       (acc_sec_ff % 32'(`WINDOW_H * HOUR_S)) == 32'h0;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_sec_ff <= '0; peak_ff <= '0;
    end else if (!acclim_ff | mode_ff == M_INIT) begin
      acc_sec_ff <= '0; peak_ff <= '0;
    end else begin
      if (sec_tick) acc_sec_ff <= acc_sec_ff + 32'h1;                // [R17]
      peak_ff <= hour_end ? '0 : (partic > peak_ff ? partic : peak_ff);
    end
  end
  genvar g;
  generate
    for (g = 0; g < 5; g++) begin : g_acc
      // twice the hourly peak, clamped into the boundaries
      wire logic [16:0] want = {peak_ff, 1'b0};
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) acc_cur_ff[g] <= 16'hffff;
        else if (!acclim_ff | !monitored)
          acc_cur_ff[g] <= acc_lo_ff[g];                            // [R18]
        else if (hour_end)                                          // [R17]
          acc_cur_ff[g] <= want > 17'(acc_lo_ff[g]) ? acc_lo_ff[g] :
                           want < 17'(acc_hi_ff[g]) ? acc_hi_ff[g] :
                           want[15:0];                               // [R18]
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // alarm compare, delay, latch, relays
  // ------------------------------------------------------------
  logic [4:0] alarm_lvl;     // threshold exceeded now
  logic [4:0] relay_req_ff;  // delayed relay request
  logic [5:0] dcnt_ff [5];
  wire logic testing = mode_ff == M_TEST;
  wire logic run = mode_ff == M_NORMAL | testing;
  wire logic clr_rel = b_reset | sw_reset_pulse | b_iso | sw_iso_pulse;
  generate
    for (g = 0; g < 5; g++) begin : g_alarm
      wire logic [15:0] thr = acclim_ff ? acc_cur_ff[g] : thr_ff[sel_set][g];
      assign alarm_lvl[g] = testing | (mode_ff == M_NORMAL & partic > thr); // [R11]
      always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          dcnt_ff[g] <= '0; relay_req_ff[g] <= 1'b0;
        end else if (clr_rel) begin                                 // [R16]
          dcnt_ff[g] <= '0; relay_req_ff[g] <= 1'b0;
        end else if (!alarm_lvl[g]) begin
          dcnt_ff[g] <= '0;
          if (!latch_ff[g]) relay_req_ff[g] <= 1'b0;                // [R23]
        end else if (dcnt_ff[g] >= dly_ff[g]) relay_req_ff[g] <= 1'b1; // [R14]
        else if (sec_tick) dcnt_ff[g] <= dcnt_ff[g] + 6'h1;
      end
    end
  endgenerate

  wire logic flt_minor = run & (flt.flow_lo_minor | flt.flow_hi_minor |
                                flt.ext_mon);                       // [R12]
  wire logic flt_urgent = run & (flt.flow_lo_urgent | flt.sensor |
                                 flt.comm | flt.fan);               // [R12]
  wire logic [3:0] seg = partic[15:12] > 4'ha ? 4'ha : partic[15:12];
  wire logic [9:0] bar;
  generate
    for (g = 0; g < 10; g++) begin : g_bar
      assign bar[g] = testing | (run & 4'(g) < seg);                // [R13]
    end
  endgenerate

  // registered outputs; isolation gates every relay but its own
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin                                             // [R25]
      alarm_relay_o <= '0; minor_relay_o <= 1'b0; urgent_relay_o <= 1'b0;
      iso_relay_o <= 1'b0; alarm_led_o <= '0; partic_led_o <= '0;
      scroll_green_o <= 1'b0; cfg_flt_led_o <= 1'b0; flt_led_o <= '0;
      iso_led_o <= 1'b0; nv_isolated_o <= 1'b0; nv_upload_open_o <= 1'b0;
      nv_configured_o <= 1'b0;
    end else begin
      alarm_relay_o  <= iso_ff | clr_rel ? '0 : relay_req_ff;       // [R22]
      minor_relay_o  <= ~iso_ff & ~clr_rel & (flt_minor | minor_cfg_ff); // [R08]
      urgent_relay_o <= ~iso_ff & ~clr_rel & (flt_urgent | urgent_cfg_ff); // [R07]
      iso_relay_o    <= iso_ff & ~(b_iso | sw_iso_pulse);           // [R21]
      iso_led_o      <= iso_ff;
      alarm_led_o    <= alarm_lvl | relay_req_ff;
      partic_led_o   <= bar;
      scroll_green_o <= mode_ff == M_SCROLL;                        // [R03]
      cfg_flt_led_o  <= cfg_flt_ff;                                 // [R06]
      flt_led_o      <= run ? flt : '0;                             // [R04]
      nv_isolated_o  <= boot_ff ? nv_iso : iso_ff;
      nv_upload_open_o <= upload_ff;                                // [R09]
      nv_configured_o  <= boot_ff ? nv_cfg : ~first_ff;
    end
  end

endmodule
`default_nettype wire

/* File: tb/panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// front panel buttons: press, hold, then let go
// ------------------------------------------------------------
module panel_model (
  input  wire logic       mclk_i,
  input  wire logic [2:0] press_i,  // one-cycle request per button
  output logic      [2:0] btn_o     // test, reset, isolate levels
);
  // per-button hold count; action happens on release
  logic [3:0] hold_ff [3] = '{3{4'h0}};
  always_ff @(posedge mclk_i)
    for (int k = 0; k < 3; k++)
      hold_ff[k] <= press_i[k] ? 4'h8 : hold_ff[k] - 4'(hold_ff[k] != 4'h0);
  always_comb
    for (int k = 0; k < 3; k++) btn_o[k] = hold_ff[k] != 4'h0;
endmodule
`default_nettype wire

/* File: tb/mode_ctrl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// relay and indicator checker
// ------------------------------------------------------------
module mode_ctrl_monitor #(
  parameter int SCROLL_C = 20   // green scroll length, cycles
) (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       fan_flt_i,
  input wire logic [4:0] alarm_relay_o,
  input wire logic       minor_relay_o,
  input wire logic       urgent_relay_o,
  input wire logic       iso_relay_o,
  input wire logic [4:0] alarm_led_o,
  input wire logic       scroll_green_o,
  input wire logic       cfg_flt_led_o,
  input wire logic [6:0] flt_led_o,
  input wire logic       iso_led_o,
  input wire logic       nv_configured_o
);
  // slack of one cycle either way on the scroll end
  localparam int SC_LO = SCROLL_C - 8;
  localparam int SC_HI = SCROLL_C - 6;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic any_rly = |alarm_relay_o | minor_relay_o | urgent_relay_o;
  rst_quiet_a: assert property ($rose(rst_n_i) |-> !any_rly && !iso_relay_o)
    else $error("relay active right after reset");
  scroll_len_a: assert property ($rose(scroll_green_o) |->
    scroll_green_o[*8] ##[SC_LO:SC_HI] $fell(scroll_green_o))
    else $error("scroll length wrong");
  unconf_led_a: assert property ($fell(scroll_green_o) && !nv_configured_o
    |-> ##[0:2] cfg_flt_led_o) else $error("unconfigured without led");
  iso_only_a: assert property (iso_relay_o |-> !any_rly)
    else $error("relay active while isolated");
  iso_first_a: assert property ($rose(iso_relay_o) |-> !$past(any_rly))
    else $error("isolation set before release");
  iso_led_a: assert property (iso_relay_o |-> iso_led_o)
    else $error("isolation led dark");
  relay_led_a: assert property (alarm_relay_o != 5'h00
    |-> (alarm_relay_o & ~alarm_led_o) == 5'h00) else $error("relay no led");
  fan_led_a: assert property (fan_flt_i [*6] |-> flt_led_o[0])
    else $error("fan fault led dark");
  c_iso: cover property ($rose(iso_relay_o));
  c_alarm: cover property (alarm_relay_o == 5'h1f);
  c_fault: cover property (urgent_relay_o && minor_relay_o);
endmodule
bind detector_mode_controller mode_ctrl_monitor #(.SCROLL_C(SCROLL_C))
  i_mode_ctrl_monitor (.*);
`default_nettype wire

/* File: tb/detector_mode_controller_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "mode_ctrl_consts.svh"
module detector_mode_controller_test;
  import mode_ctrl_pkg::*;
  // ------------------------------------------------------------
  // stimulus, wiring and shared tasks
  // ------------------------------------------------------------
  localparam int SCROLL = 20;       // shortened scroll
  localparam int INIT   = 30;       // 3 s at 10 cycles a second
  logic        mclk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0;
  logic        penable_i = 1'b0, pwrite_i = 1'b0, last_err;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, rdat, prdata_o;
  logic [15:0] partic_i = 16'h0, airflow_i = 16'h0100;
  logic        nv_configured_i = 1'b0, nv_isolated_i = 1'b0;
  logic        nv_upload_open_i = 1'b0;
  logic [2:0]  press = 3'h0;        // isolate, reset, test by bit
  fault_t      flt = 7'h00;         // injected fault levels
  wire logic   btn_test_i, btn_reset_i, btn_iso_i, flow_lo_minor_i;
  wire logic   flow_lo_urgent_i, flow_hi_minor_i, sensor_flt_i;
  wire logic   ext_mon_flt_i, comm_flt_i, fan_flt_i;
  logic [9:0]  partic_led_o;
  logic [6:0]  flt_led_o;
  logic [4:0]  alarm_relay_o, alarm_led_o;
  logic        pready_o, pslverr_o, minor_relay_o, urgent_relay_o;
  logic        iso_relay_o, scroll_green_o, cfg_flt_led_o, iso_led_o;
  logic        nv_isolated_o, nv_upload_open_o, nv_configured_o;
  int          err_count = 0, check_count = 0;
  assign {flow_lo_minor_i, flow_lo_urgent_i, flow_hi_minor_i, sensor_flt_i,
          ext_mon_flt_i, comm_flt_i, fan_flt_i} = flt;
  always #2 mclk_i = ~mclk_i;
  detector_mode_controller #(.SEC_CYC(10), .INIT_S(3), .SCROLL_C(SCROLL),
    .HOUR_S(2)) i_detector_mode_controller (.*);
  panel_model i_panel_model (.mclk_i, .press_i(press),
    .btn_o({btn_test_i, btn_reset_i, btn_iso_i}));
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test;
    if (err_count == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    rdat = prdata_o;
    last_err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic mode_is(mode_t m);
    apb(1'b0, `REG_STATUS, 32'h0);
    chk("mode", rdat[4:2], m);
  endtask
  task automatic push(int k);
    press[k] <= 1'b1;
    @(posedge mclk_i);
    press[k] <= 1'b0;
    repeat (24) @(posedge mclk_i);
  endtask
  function automatic logic [31:0] thr(int k);
    return 32'h64 * (k + 1);
  endfunction
  function automatic logic [4:0] lvl(logic [15:0] p);
    for (int k = 0; k < 5; k++) lvl[k] = p > thr(k);
  endfunction
  // open upload, same thresholds in all sets, zero delays, then cmd
  task automatic upload(logic [31:0] cmd);
    apb(1'b1, `REG_CFG_CMD, 32'h1);
    for (int i = 0; i < 15; i++) apb(1'b1, `REG_THR_BASE + 12'(4*i), thr(i % 5));
    for (int i = 0; i < 5; i++) apb(1'b1, `REG_DLY_BASE + 12'(4*i), 32'h0);
    apb(1'b1, `REG_CFG_CMD, cmd);
  endtask
  initial begin
    int seed_v;
    logic [15:0] p;
    seed_v = $urandom(32'hca54);
    repeat (6) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (SCROLL + 6) @(posedge mclk_i);
    chk("cfg led", cfg_flt_led_o, 1'b1);
    chk("urgent", urgent_relay_o, 1'b1);
    apb(1'b0, 12'h7fc, 32'h0);
    chk("slverr", {last_err, rdat[30:0]}, 32'h80000000);
    upload(32'h2);
    chk("urgent,cfg led", {urgent_relay_o, cfg_flt_led_o}, 2'h3);
    upload(32'h6);
    mode_is(M_INIT);
    repeat (INIT + 8) @(posedge mclk_i);
    mode_is(M_NORMAL);
    chk("cfg led", cfg_flt_led_o, 1'b0);
    for (int i = 0; i < 12; i++) begin
      p = (i < 5) ? 16'(thr(i)) : 16'($urandom_range(16'h258));
      partic_i <= p;
      repeat (16) @(posedge mclk_i);
      chk("alarm led,relay", {alarm_led_o, alarm_relay_o}, {2{lvl(p)}});
    end
    flt <= 7'h7f;
    repeat (8) @(posedge mclk_i);
    chk("fault leds", flt_led_o, 7'h7f);
    chk("fault relays", {urgent_relay_o, minor_relay_o}, 2'h3);
    flt <= 7'h00;
    apb(1'b1, `REG_CTRL, 32'h2);
    repeat (8) @(posedge mclk_i);
    chk("relays", {urgent_relay_o, minor_relay_o, alarm_relay_o}, lvl(p));
    push(2);
    mode_is(M_NORMAL);
    apb(1'b1, `REG_CFG_CMD, 32'h1);
    apb(1'b1, `REG_LOCK, 32'h0);
    push(2);
    mode_is(M_TEST);
    chk("bar leds", {alarm_led_o, partic_led_o}, 15'h7fff);
    chk("alarm relay", alarm_relay_o, 5'h1f);
    push(1);
    mode_is(M_NORMAL);
    upload(32'h2);
    repeat (4) @(posedge mclk_i);
    chk("urgent,minor", {urgent_relay_o, minor_relay_o}, 2'h1);
    partic_i <= 16'h0300;
    push(0);
    chk("iso relay,led", {iso_relay_o, iso_led_o}, 2'h3);
    chk("alarm led,relay", {alarm_led_o, alarm_relay_o}, 10'h3e0);
    apb(1'b1, `REG_CTRL, 32'h2);
    repeat (8) @(posedge mclk_i);
    chk("iso relay", iso_relay_o, 1'b1);
    push(0);
    chk("alarm relay", {iso_relay_o, alarm_relay_o}, 6'h1f);
    end_of_test();
  end
  // watchdog, well beyond the several hundred cycles the run needs
  initial begin
    #60000;
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
